// ===== acs_pkg.sv
/*
 * Package for the converter scan and snapshot control block: register
 * indices, control field positions, channel codes, timing and carriers.
 * Assumes a byte-wide register access port from the serial bus slave.
 */
package acs_pkg;

	// ==========================================================
	// Register indices (byte registers, chosen offsets)
	localparam logic [7:0] REG_CONTROL   = 8'h00;
	localparam logic [7:0] REG_SENSE_HI  = 8'h14;
	localparam logic [7:0] REG_SENSE_LO  = 8'h15;
	localparam logic [7:0] REG_SUPPLY_HI = 8'h1E;
	localparam logic [7:0] REG_SUPPLY_LO = 8'h1F;
	localparam logic [7:0] REG_AUX_HI    = 8'h28;
	localparam logic [7:0] REG_AUX_LO    = 8'h29;

	// ==========================================================
	// Control register field positions
	localparam int CTL_SNAP_REQ  = 7;
	localparam int CTL_CH_HI     = 6;
	localparam int CTL_CH_LO     = 5;
	localparam int CTL_BUSY      = 3;
	localparam int CTL_SRC_HI    = 2;
	localparam int CTL_PWR_DOWN  = 1;
	localparam int CTL_SRC_LO    = 0;
	localparam logic [7:0] CTL_RESET     = 8'h05;
	localparam logic [7:0] CTL_WR_MASK   = 8'hF7;
	localparam logic [3:0] LOW_NIBBLE_ZERO = 4'h0;

	// ==========================================================
	// Channel codes for snapshot selection and the scan order
	typedef enum logic [1:0] {
		ACS_CH_SENSE  = 2'b00,
		ACS_CH_SUPPLY = 2'b01,
		ACS_CH_AUX    = 2'b10
	} acs_chan_t;

	// Supply channel source codes {hi,lo}
	localparam logic [1:0] SRC_HIGH_SENSE = 2'b11;
	localparam logic [1:0] SRC_SUPPLY_PIN = 2'b01;
	localparam logic [1:0] SRC_AUX_INPUT  = 2'b10;

	// ==========================================================
	// Timing: per-channel slot so each channel refreshes at 7.5 Hz
	localparam real REFRESH_HZ   = 7.5;
	localparam real CLK_HZ       = 200.0e6;
	localparam int  SCAN_CHANS   = 3;
	localparam int  SLOT_CYCLES  =
		int'(CLK_HZ / (REFRESH_HZ * SCAN_CHANS));

	// Step sizes of one result code, in microvolts
	localparam int LSB_SENSE_UV  = 25;
	localparam int LSB_SUPPLY_UV = 25000;
	localparam int LSB_AUX_UV    = 500;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic       wr;    // Write strobe
		logic [7:0] addr;  // Register index
		logic [7:0] wdata; // Write data
	} acs_reg_req_t;

	typedef struct packed {
		logic        start;   // Start a conversion
		logic [1:0]  chan;    // Channel to convert
		logic [1:0]  src;     // Supply channel source
		logic        enable;  // Converter and reference powered
	} acs_conv_cmd_t;

endpackage

// ===== acs_scan_ctrl.sv
/*
 * Converter scan and snapshot control: sequences the three-channel scan,
 * runs snapshot conversions, formats results into byte register pairs,
 * handles shutdown and supply lockout gating.
 * Assumes the serial bus slave presents byte register accesses on i_clk,
 * and the analog core signals each conversion end with a done pulse.
 */
// Summary of operation
// - Scan order: sense differential, selected supply, auxiliary input, repeated.
// - Result bits 11:4 go to high register, 3:0 to low upper nibble.
// - Low four bits of every low data register read as zero.
// - Pair written right after its conversion; scan refresh per channel 7.5 Hz.
// - Code step: 25 uV sense, 25 mV supply, 0.5 mV auxiliary.
// - Snapshot write starts conversion; busy bit set throughout.
// - Snapshot end halts converter and clears busy.
// - No snapshot restarts alone; host rewrites control for each one.
// - Logic and converter enable when either supply clears lockout.
// - Lockout disables converter only when both supplies are below lockout.
// - Power-down bit stops converter and reference; clearing resumes scans.
// - In shutdown bus stays active, address pins ignored, address held.
// - Shutdown changes no register except clearing the busy bit; all stay readable and writable.
// - Shutdown also switches off the internal regulator.
// - After reset the converter runs continuous scan.
// - Source bits pick supply: 11 high sense, 01 pin, 10 auxiliary.
`timescale 1ns/100ps
`default_nettype none

module acs_scan_ctrl #(
	parameter int SLOT_CYCLES = acs_pkg::SLOT_CYCLES
) (
	input  wire logic                 i_clk,        // Core clock
	input  wire logic                 i_nrst,       // Sync reset, low
	input  wire logic                 i_ce,         // Clock enable
	input  wire acs_pkg::acs_reg_req_t i_reg,       // Register access
	input  wire logic [7:0]           i_rd_addr,    // Read index
	output logic [7:0]                o_rd_data,    // Read data
	input  wire logic                 i_hv_ok,      // High supply above lockout
	input  wire logic                 i_lv_ok,      // Low supply above lockout
	input  wire logic [1:0]           i_addr_pins,  // Bus address pins
	output logic [1:0]                o_bus_addr,   // Held bus address
	input  wire logic                 i_conv_done,  // Analog conversion end
	input  wire logic [11:0]          i_conv_code,  // Analog result code
	output acs_pkg::acs_conv_cmd_t    o_conv_cmd,   // Analog command
	output logic                      o_reg_enable  // Internal regulator on
);

	// ==========================================================
	// Elaboration checks
	if (SLOT_CYCLES < 2) begin : g_chk
		$error("SLOT_CYCLES too small");
	end

	typedef enum logic [1:0] {
		ST_OFF  = 2'b00,
		ST_IDLE = 2'b01,
		ST_CONV = 2'b11,
		ST_WAIT = 2'b10
	} acs_state_t;

	// ==========================================================
	// Input synchronisers for supply flags and address pins
	logic [3:0] sync1;
	logic [3:0] sync2;
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else if (i_ce) begin
			sync1 <= {i_hv_ok, i_lv_ok, i_addr_pins};
			sync2 <= sync1;
		end
	end
	logic supply_ok;
	assign supply_ok = sync2[3] | sync2[2];

	// ==========================================================
	// State
	acs_state_t state;
	acs_state_t next_state;
	logic [7:0] ctl;
	logic [7:0] next_ctl;
	logic [7:0] data_hi [3];
	logic [3:0] data_lo [3];
	logic [7:0] next_hi [3];
	logic [3:0] next_lo [3];
	logic [1:0] chan;
	logic [1:0] next_chan;
	logic       snap;
	logic       next_snap;
	logic [31:0] slot;
	logic [31:0] next_slot;
	logic [1:0] bus_addr;
	logic [1:0] next_bus_addr;
	logic        snap_wr;
	logic        pwr_down;
	logic [1:0]  src;

	assign pwr_down = ctl[acs_pkg::CTL_PWR_DOWN];
	assign src = {ctl[acs_pkg::CTL_SRC_HI], ctl[acs_pkg::CTL_SRC_LO]};
	assign snap_wr = i_reg.wr && i_reg.addr == acs_pkg::REG_CONTROL
		&& i_reg.wdata[acs_pkg::CTL_SNAP_REQ];

	// Next channel in scan order
	function automatic logic [1:0] scan_next(input logic [1:0] c);
		unique case (c)
			acs_pkg::ACS_CH_SENSE:  scan_next = acs_pkg::ACS_CH_SUPPLY;
			acs_pkg::ACS_CH_SUPPLY: scan_next = acs_pkg::ACS_CH_AUX;
			default:                scan_next = acs_pkg::ACS_CH_SENSE;
		endcase
	endfunction

	// ==========================================================
	// Sequencer, control and result registers
	always_comb begin
		next_state    = state;
		next_ctl      = ctl;
		next_chan     = chan;
		next_snap     = snap;
		next_slot     = slot;
		next_bus_addr = bus_addr;
		for (int k = 0; k < 3; k++) begin
			next_hi[k] = data_hi[k];
			next_lo[k] = data_lo[k];
		end
		// Address pins only followed while powered up
		if (!pwr_down) begin
			next_bus_addr = sync2[1:0];
		end
		// Host writes; busy bit is not writable
		if (i_reg.wr) begin
			unique case (i_reg.addr)
				acs_pkg::REG_CONTROL: next_ctl =
					(i_reg.wdata & acs_pkg::CTL_WR_MASK)
					| (ctl & ~acs_pkg::CTL_WR_MASK);
				acs_pkg::REG_SENSE_HI:  next_hi[0] = i_reg.wdata;
				acs_pkg::REG_SENSE_LO:  next_lo[0] = i_reg.wdata[7:4];
				acs_pkg::REG_SUPPLY_HI: next_hi[1] = i_reg.wdata;
				acs_pkg::REG_SUPPLY_LO: next_lo[1] = i_reg.wdata[7:4];
				acs_pkg::REG_AUX_HI:    next_hi[2] = i_reg.wdata;
				acs_pkg::REG_AUX_LO:    next_lo[2] = i_reg.wdata[7:4];
				default: ;
			endcase
		end
		if (next_slot != 32'h0000_0000) begin
			next_slot = slot - 32'h0000_0001;
		end
		unique case (state)
			ST_OFF: begin
				if (supply_ok && !pwr_down) begin
					next_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (snap_wr) begin
					next_snap = 1'b1;
					next_chan = i_reg.wdata[acs_pkg::CTL_CH_HI:
						acs_pkg::CTL_CH_LO];
					next_ctl[acs_pkg::CTL_BUSY] = 1'b1;
					next_state = ST_CONV;
				end else if (!snap) begin
					next_state = ST_CONV;
				end
			end
			ST_CONV: begin
				if (i_conv_done) begin
					// Format the result into the pair
					next_hi[chan] = i_conv_code[11:4];
					next_lo[chan] = i_conv_code[3:0];
					if (snap) begin
						next_ctl[acs_pkg::CTL_BUSY] = 1'b0;
						next_state = ST_IDLE;
					end else begin
						next_slot  = 32'(SLOT_CYCLES);
						next_state = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (slot == 32'h0000_0000) begin
					next_chan  = scan_next(chan);
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_OFF;
		endcase
		// A snapshot request in scan mode takes over at once, cutting the running slot short
		if (snap_wr && state != ST_IDLE && state != ST_OFF) begin
			next_snap = 1'b1;
			next_chan = i_reg.wdata[acs_pkg::CTL_CH_HI:acs_pkg::CTL_CH_LO];
			next_ctl[acs_pkg::CTL_BUSY] = 1'b1;
			next_state = ST_CONV;
		end
		// Shutdown or lockout halt the converter, clear busy, keep data registers
		if (!supply_ok || next_ctl[acs_pkg::CTL_PWR_DOWN]) begin
			next_state = ST_OFF;
			next_ctl[acs_pkg::CTL_BUSY] = 1'b0;
			// Restart the scan from sense, not from the interrupted channel
			next_snap = 1'b0;
			next_chan = acs_pkg::ACS_CH_SENSE;
		end
		if (!next_ctl[acs_pkg::CTL_PWR_DOWN]
			&& ctl[acs_pkg::CTL_PWR_DOWN]) begin
			next_snap = 1'b0; // Resume scanning
			next_chan = acs_pkg::ACS_CH_SENSE;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			state    <= ST_OFF;
			ctl      <= acs_pkg::CTL_RESET;
			chan     <= acs_pkg::ACS_CH_SENSE;
			snap     <= 1'b0;
			slot     <= 32'h0000_0000;
			bus_addr <= 2'h0;
			for (int k = 0; k < 3; k++) begin
				data_hi[k] <= 8'h00;
				data_lo[k] <= 4'h0;
			end
		end else if (i_ce) begin
			state    <= next_state;
			ctl      <= next_ctl;
			chan     <= next_chan;
			snap     <= next_snap;
			slot     <= next_slot;
			bus_addr <= next_bus_addr;
			for (int k = 0; k < 3; k++) begin
				data_hi[k] <= next_hi[k];
				data_lo[k] <= next_lo[k];
			end
		end
	end

	// ==========================================================
	// Register read mux, low nibbles forced to zero
	always_comb begin
		unique case (i_rd_addr)
			acs_pkg::REG_CONTROL:   o_rd_data = ctl;
			acs_pkg::REG_SENSE_HI:  o_rd_data = data_hi[0];
			acs_pkg::REG_SENSE_LO:  o_rd_data =
				{data_lo[0], acs_pkg::LOW_NIBBLE_ZERO};
			acs_pkg::REG_SUPPLY_HI: o_rd_data = data_hi[1];
			acs_pkg::REG_SUPPLY_LO: o_rd_data =
				{data_lo[1], acs_pkg::LOW_NIBBLE_ZERO};
			acs_pkg::REG_AUX_HI:    o_rd_data = data_hi[2];
			acs_pkg::REG_AUX_LO:    o_rd_data =
				{data_lo[2], acs_pkg::LOW_NIBBLE_ZERO};
			default:                o_rd_data = 8'h00;
		endcase
	end

	// ==========================================================
	// Analog command: scale per channel is the core's (25uV/25mV/0.5mV)
	// Start from idle, or a snapshot taking over a running scan
	assign o_conv_cmd.start  = i_ce && next_state == ST_CONV
		&& (state == ST_IDLE || snap_wr);
	assign o_conv_cmd.chan   = next_chan;
	assign o_conv_cmd.src    = src;
	assign o_conv_cmd.enable = state != ST_OFF;
	assign o_reg_enable      = !pwr_down;
	assign o_bus_addr        = bus_addr;

endmodule

`default_nettype wire

// ===== acs_scan_ctrl_asserts.sv
/* Port checker for acs_scan_ctrl, bound into every instance.
 * Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Checker
module acs_scan_ctrl_asserts #(
	parameter int SLOT_CYCLES = 20
) (
	input wire logic                   i_clk,        // Clock
	input wire logic                   i_nrst,       // Reset, low
	input wire logic                   i_ce,         // Clock enable
	input wire acs_pkg::acs_reg_req_t  i_reg,        // Register write
	input wire logic [7:0]             i_rd_addr,    // Read index
	input wire logic [7:0]             o_rd_data,    // Read data
	input wire logic                   i_hv_ok,      // High supply ok
	input wire logic                   i_lv_ok,      // Low supply ok
	input wire logic [1:0]             i_addr_pins,  // Address pins
	input wire logic [1:0]             o_bus_addr,   // Held address
	input wire logic                   i_conv_done,  // Conversion end
	input wire logic [11:0]            i_conv_code,  // Result code
	input wire acs_pkg::acs_conv_cmd_t o_conv_cmd,   // Core command
	input wire logic                   o_reg_enable  // Regulator on
);
	wire logic  ctl_wr = i_ce && i_reg.wr
		&& i_reg.addr == acs_pkg::REG_CONTROL;
	wire logic  lo_rd = i_rd_addr == acs_pkg::REG_SENSE_LO
		|| i_rd_addr == acs_pkg::REG_SUPPLY_LO
		|| i_rd_addr == acs_pkg::REG_AUX_LO;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	lo_nibble_a: assert property (lo_rd |-> o_rd_data[3:0] == 4'h0)
		else $error("low data nibble not zero");
	reg_follow_a: assert property (ctl_wr
		|=> o_reg_enable == !$past(i_reg.wdata[1]))
		else $error("regulator does not follow power down bit");
	reg_hold_a: assert property (!ctl_wr |=> $stable(o_reg_enable))
		else $error("regulator changed without control write");
	shutdown_stop_a: assert property (ctl_wr && i_reg.wdata[1]
		|-> ##[1:3] !o_conv_cmd.enable)
		else $error("converter still powered in shutdown");
	snap_start_a: assert property (ctl_wr && i_reg.wdata[7]
		&& !i_reg.wdata[1] && i_reg.wdata[6:5] != 2'h3
		&& o_conv_cmd.enable
		|-> (o_conv_cmd.start && o_conv_cmd.chan == i_reg.wdata[6:5]))
		else $error("snapshot did not start on its channel");
	start_pulse_a: assert property (o_conv_cmd.start
		|=> !o_conv_cmd.start)
		else $error("start longer than one cycle");
	lockout_off_a: assert property ((!i_hv_ok && !i_lv_ok)[*5]
		|-> !o_conv_cmd.enable)
		else $error("converter on with both supplies low");
	lockout_on_a: assert property (((i_hv_ok || i_lv_ok)
		&& o_reg_enable)[*8] |-> o_conv_cmd.enable)
		else $error("converter off with a supply up");
	addr_hold_a: assert property ((!o_reg_enable)[*3]
		|-> $stable(o_bus_addr))
		else $error("bus address moved in shutdown");
	cover property (ctl_wr && i_reg.wdata[7]);
	cover property (!o_reg_enable);
	cover property (i_conv_done && o_conv_cmd.enable);
endmodule
bind acs_scan_ctrl acs_scan_ctrl_asserts #(.SLOT_CYCLES(SLOT_CYCLES)) chk_u (
	.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_reg(i_reg),
	.i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data), .i_hv_ok(i_hv_ok),
	.i_lv_ok(i_lv_ok), .i_addr_pins(i_addr_pins), .o_bus_addr(o_bus_addr),
	.i_conv_done(i_conv_done), .i_conv_code(i_conv_code),
	.o_conv_cmd(o_conv_cmd), .o_reg_enable(o_reg_enable));
`default_nettype wire

// ===== acs_conv_model.sv
/* Behavioural converter core for the scan control bench.
 * Assumes commands from acs_scan_ctrl on the same clock. */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Converter core model
module acs_conv_model (
	input  wire logic                   i_clk,  // Core clock
	input  wire acs_pkg::acs_conv_cmd_t i_cmd,  // Command
	input  wire logic [3:0]             i_lat,  // Latency of next start
	output logic                        o_done, // End pulse
	output logic [11:0]                 o_code  // Result code
);
	logic        busy = 1'b0;
	logic [3:0]  cnt = 4'h0;
	logic [11:0] res = 12'h5a3;
	initial o_done = 1'b0;
	initial o_code = 12'h000;
	// Convert once per start; code scrambled outside the pulse
	always @(posedge i_clk) begin
		o_done <= 1'b0;
		o_code <= ~o_code;
		if (!i_cmd.enable) begin
			busy <= 1'b0;
		end else if (i_cmd.start) begin
			busy <= 1'b1;
			cnt <= i_lat;
			res <= {res[10:0], res[11] ^ res[5]} ^ {i_cmd.chan, 10'h000};
		end else if (busy && cnt == 4'h0) begin
			busy <= 1'b0;
			o_done <= 1'b1;
			o_code <= res;
		end else if (busy) begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule
`default_nettype wire

// ===== tb_adc_scan_snapshot_control.sv
/* Self-checking bench for acs_scan_ctrl with a converter core model.
 * Assumes package, design, model and checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Bench top
module tb_adc_scan_snapshot_control;
	localparam int SLOT = 20;
	localparam logic [7:0] CTL = acs_pkg::REG_CONTROL;
	localparam logic [7:0] RA [6] = '{acs_pkg::REG_SENSE_HI,
		acs_pkg::REG_SENSE_LO, acs_pkg::REG_SUPPLY_HI,
		acs_pkg::REG_SUPPLY_LO, acs_pkg::REG_AUX_HI, acs_pkg::REG_AUX_LO};
	logic i_clk = 1'b0, i_nrst = 1'b0, i_hv_ok = 1'b1, i_lv_ok = 1'b0;
	logic done, rena, snap = 1'b0, used = 1'b0;
	logic [1:0] pins = 2'h0, baddr, keep;
	logic [3:0] lat = 4'h0;
	logic [7:0] rda = 8'h00, rdd;
	logic [11:0] code;
	logic [31:0] rng = 32'h12c5_a249;
	acs_pkg::acs_reg_req_t req = '0;
	acs_pkg::acs_conv_cmd_t cmd;
	int fails, samples_checked, cyc, ech, cch, nst, gap = 9999;
	logic [7:0] mem [6] = '{default: 8'h00};
	acs_scan_ctrl #(.SLOT_CYCLES(SLOT)) dut_u (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_ce(1'b1), .i_reg(req), .i_rd_addr(rda), .o_rd_data(rdd),
		.i_hv_ok(i_hv_ok), .i_lv_ok(i_lv_ok), .i_addr_pins(pins),
		.o_bus_addr(baddr), .i_conv_done(done), .i_conv_code(code),
		.o_conv_cmd(cmd), .o_reg_enable(rena));
	acs_conv_model core_u (.i_clk(i_clk), .i_cmd(cmd), .i_lat(lat),
		.o_done(done), .o_code(code));
	// Clock
	initial begin
		forever #2.5 i_clk = ~i_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic chk(input string n, input logic [7:0] e, logic [7:0] s);
		samples_checked++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			fails++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		req = '{1'b1, a, d};
		@(negedge i_clk);
		req.wr = 1'b0;
	endtask
	task automatic regs();
		for (int i = 0; i < 6; i++) begin
			@(negedge i_clk);
			rda = RA[i];
			#1 chk($sformatf("reg %h", RA[i]), mem[i], rdd);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Expected scan order and data register contents
	always @(posedge i_clk) begin
		cyc++;
		gap++;
		if (cmd.start && cmd.enable) begin
			chk("start chan", 8'(ech), {6'h00, cmd.chan});
			if (!snap && gap < 999)
				chk("slot", 8'h01, 8'(gap >= SLOT && gap <= SLOT + 2));
			if (snap) chk("snapshot rerun", 8'h00, {7'h00, used});
			used = snap;
			cch = ech;
			nst++;
			lat <= rng[3:0];
			rng = xs(rng);
		end
		if (done) begin
			mem[2 * cch] = code[11:4];
			mem[2 * cch + 1] = {code[3:0], 4'h0};
			ech = snap ? cch : (cch + 1) % 3;
			gap = 0;
		end
	end
	// Cycle ceiling
	always @(posedge i_clk) if (cyc == 20000) begin
		fails++;
		finish_test();
	end
	// Main sequence
	initial begin
		int n;
		repeat (3) @(negedge i_clk);
		i_nrst = 1'b1;
		pins = rng[1:0];
		@(negedge i_clk);
		rda = CTL;
		#1 chk("control reset", acs_pkg::CTL_RESET, rdd);
		regs();
		chk("bus addr", {6'h00, pins}, {6'h00, baddr});
		wait (nst >= 7);
		@(posedge i_clk iff done);
		for (int c = 0; c < 3; c++) begin
			@(negedge i_clk);
			{snap, used, ech} = {2'b10, c};
			wr(CTL, 8'h85 | 8'(c << 5));
			@(negedge i_clk);
			rda = CTL;
			#1 chk("busy set", 8'h08, rdd & 8'h08);
			for (int k = 0; k < 40 && rdd[3] !== 1'b0; k++) @(negedge i_clk);
			chk("busy clear", 8'h00, rdd & 8'h08);
			repeat (3 * SLOT) @(negedge i_clk);
			regs();
		end
		wr(CTL, 8'h07);
		repeat (4) @(negedge i_clk);
		keep = baddr;
		chk("regulator", 8'h00, {7'h00, rena});
		chk("conv enable", 8'h00, {7'h00, cmd.enable});
		pins = ~pins;
		repeat (6) @(negedge i_clk);
		chk("bus addr", {6'h00, keep}, {6'h00, baddr});
		mem[0] = rng[7:0];
		mem[5] = rng[15:8] & 8'hf0;
		wr(RA[0], rng[7:0]);
		wr(RA[5], rng[15:8]);
		regs();
		for (int s = 1; s < 4; s++) begin
			wr(CTL, {5'h00, 1'(s >> 1), 1'b1, 1'(s)});
			chk("source", 8'(s), {6'h00, cmd.src});
		end
		snap = 1'b0;
		ech = 0;
		gap = 9999;
		n = nst + 4;
		wr(CTL, 8'h05);
		wait (nst >= n);
		@(negedge i_clk);
		{i_lv_ok, i_hv_ok} = 2'b10;
		repeat (8) @(negedge i_clk);
		chk("one supply", 8'h01, {7'h00, cmd.enable});
		i_lv_ok = 1'b0;
		repeat (6) @(negedge i_clk);
		chk("no supply", 8'h00, {7'h00, cmd.enable});
		ech = 0;
		gap = 9999;
		i_lv_ok = 1'b1;
		repeat (8) @(negedge i_clk);
		chk("low supply", 8'h01, {7'h00, cmd.enable});
		finish_test();
	end
endmodule
`default_nettype wire
